// *** src/hbcs_params.svh ***
// Purpose: Constants for the hub boot configuration sequencer
// Assumes: 100 MHz clk, synchronous active-low reset
// Notes: Offsets are byte addresses on the register bus
`ifndef HBCS_PARAMS_SVH
`define HBCS_PARAMS_SVH
`define HBCS_SIG_ADDR 24'h03fffa
`define HBCS_EXEC_ADDR 24'h000000
`define HBCS_SIG_WORD 32'h32444655
`define HBCS_LEGACY_END_REG 8'hff
`define HBCS_OP_ATTACH 16'haa55
`define HBCS_OP_ATTACH_KEEP 16'haa56
`define HBCS_CFG_ONE 3'h1
`define HBCS_REG_CTRL 12'h000
`define HBCS_REG_STATUS 12'h004
`define HBCS_REG_CFG 12'h008
`define HBCS_REG_STRAPS 12'h00c
`define HBCS_REG_HOST 12'h010
`define HBCS_REG_OTP 12'h014
`define HBCS_REG_ROM 12'h018
`define HBCS_CTRL_RST 32'h00000000
`define HBCS_ROM_DEFAULT 32'h00000000
`define HBCS_RESP_OKAY 2'h0
`define HBCS_RESP_SLVERR 2'h2
`endif

// *** src/hbcs_pkg.sv ***
// Purpose: Types for the hub boot configuration sequencer
// Assumes: Constants come from hbcs_params.svh
// Notes: Stage list follows the boot flow
package hbcs_pkg;
   typedef enum logic [3:0] {
      StStandby, StFlashProbe, StFlashExec, StCfgRom, StStrap, StPullProbe,
      StHostCfg, StOtpMerge, StAttach, StNormal
   } hbcs_stage_t;
   typedef struct packed {
      logic [2:0] configSelect;
      logic [5:0] ssDisable;
      logic [5:0] hsDisable;
      logic nonRemovable;
      logic chargeEnable;
      logic flashMode;
   } hbcs_straps_t;
   typedef struct packed {
      logic valid;
      logic legacyWrite;
      logic [7:0] regAddr;
      logic [15:0] opcode;
   } hbcs_host_cmd_t;
   typedef struct packed {
      logic req;
      logic [23:0] addr;
      logic [1:0] lanes;
      logic cpol;
   } hbcs_flash_req_t;
endpackage : hbcs_pkg

// *** src/hbcs_sequencer.sv ***
// Purpose: Boot stage sequencer with AXI4-Lite register access
// Assumes: Flash reader, SMBus slave and pull-up probe sit outside
// Notes: Pin straps pass a three-flop filter
`include "hbcs_params.svh"
module hbcs_sequencer (
   input wire logic clk,
   input wire logic reset_n,
   input wire hbcs_pkg::hbcs_straps_t strapPins,
   input wire logic pullUpsFound,
   input wire logic pullProbeDone,
   output hbcs_pkg::hbcs_flash_req_t flashReq,
   input wire logic flashDone,
   input wire logic [31:0] flashData,
   input wire hbcs_pkg::hbcs_host_cmd_t hostCmd,
   input wire logic hostConnected,
   input wire logic softDisconnect,
   output logic pullProbeStart,
   output logic smbusSlaveEn,
   output logic highspeedAttach,
   output logic superspeedHubEnable,
   output logic portsEnable,
   output logic pllRun,
   output logic flashExecute,
   output logic [31:0] mergedCfg,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import hbcs_pkg::*;

   hbcs_stage_t stage_q, stage_d;
   hbcs_straps_t sync1_q, sync2_q, sync3_q, straps_q;
   logic [31:0] ctrl_q, cfg_q, hostCfg_q, hostMask_q, otpCfg_q, otpMask_q;
   logic [2:0] ctrlLanes;
   logic ctrlCpol;
   logic stageDone;
   logic hostEnd;
   logic sigOk;
   logic reqSent_q;
   logic [11:0] awAddr_q, arAddr_q;
   logic awHeld_q, wHeld_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;

   // Strap sync flops run through reset, so straps_q loads settled straps on the first clock after release
   always_ff @(posedge clk) begin
      sync1_q <= strapPins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (!reset_n) begin
         straps_q <= '0;
      end else if (sync2_q == sync3_q) begin
         straps_q <= sync3_q;
      end
   end

   assign ctrlLanes = ctrl_q[2:0];
   assign ctrlCpol = ctrl_q[3];
   assign sigOk = flashData == `HBCS_SIG_WORD;
   assign hostEnd = hostCmd.valid && ((hostCmd.legacyWrite
      && hostCmd.regAddr == `HBCS_LEGACY_END_REG)
      || (!hostCmd.legacyWrite && (hostCmd.opcode == `HBCS_OP_ATTACH
      || hostCmd.opcode == `HBCS_OP_ATTACH_KEEP)));

   // Stage moves; each leaves only when its action completes
   always_comb begin
      stage_d = stage_q;
      unique case (stage_q)
         StStandby: stage_d = StFlashProbe;
         StFlashProbe: begin
            if (!straps_q.flashMode) begin
               stage_d = StCfgRom;
            end else if (flashDone) begin
               stage_d = sigOk ? StFlashExec : StCfgRom;
            end
         end
         StFlashExec: stage_d = StFlashExec;
         StCfgRom: stage_d = StStrap;
         StStrap: begin
            stage_d = (straps_q.configSelect == `HBCS_CFG_ONE) ? StPullProbe
               : StOtpMerge;
         end
         StPullProbe: begin
            if (pullProbeDone) begin
               stage_d = pullUpsFound ? StHostCfg : StOtpMerge;
            end
         end
         StHostCfg: if (hostEnd) stage_d = StOtpMerge;
         StOtpMerge: stage_d = StAttach;
         StAttach: if (hostConnected && !softDisconnect) stage_d = StNormal;
         StNormal: if (softDisconnect) stage_d = StAttach;
      endcase
   end
   assign stageDone = stage_d != stage_q;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         stage_q <= StStandby;
         reqSent_q <= 1'b0;
      end else begin
         stage_q <= stage_d;
         reqSent_q <= (stage_q == StFlashProbe) && !flashDone;
      end
   end

   // Flash probe request: one pulse on entry, lanes and polarity from ctrl
   assign flashReq.req = (stage_q == StFlashProbe) && straps_q.flashMode
      && !reqSent_q;
   assign flashReq.addr = (stage_q == StFlashExec) ? `HBCS_EXEC_ADDR
      : `HBCS_SIG_ADDR;
   assign flashReq.lanes = ctrlLanes[2] ? 2'h2 : (ctrlLanes[1] ? 2'h1 : 2'h0);
   assign flashReq.cpol = ctrlCpol;

   // Config: ROM loads, straps override, host merges, OTP wins
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cfg_q <= `HBCS_ROM_DEFAULT;
         hostCfg_q <= '0;
         hostMask_q <= '0;
      end else begin
         if (stage_q == StCfgRom) begin
            cfg_q <= `HBCS_ROM_DEFAULT;
         end else if (stage_q == StStrap) begin
            cfg_q[16:0] <= {straps_q.configSelect, straps_q.ssDisable,
               straps_q.hsDisable, straps_q.nonRemovable,
               straps_q.chargeEnable};
         end else if (stage_q == StOtpMerge) begin
            cfg_q <= (((cfg_q & ~hostMask_q) | (hostCfg_q & hostMask_q))
               & ~otpMask_q) | (otpCfg_q & otpMask_q);
         end
         if (awHeld_q && wHeld_q && awAddr_q == `HBCS_REG_HOST
            && stage_q == StHostCfg) begin
            hostCfg_q <= wData_q;
            hostMask_q <= hostMask_q | {{8{wStrb_q[3]}}, {8{wStrb_q[2]}},
               {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
         end
      end
   end

   assign pullProbeStart = stage_q == StPullProbe;
   assign smbusSlaveEn = stage_q == StHostCfg;
   assign highspeedAttach = (stage_q == StAttach) || (stage_q == StNormal);
   assign superspeedHubEnable = highspeedAttach;
   assign portsEnable = stage_q == StNormal;
   assign pllRun = stage_q != StStandby;
   assign flashExecute = stage_q == StFlashExec;
   assign mergedCfg = cfg_q;

   // AXI4-Lite write: address and data taken in either order
   logic doWrite;
   logic wrHit;
   assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
   assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
   assign doWrite = awHeld_q && wHeld_q;
   assign wrHit = awAddr_q == `HBCS_REG_CTRL || awAddr_q == `HBCS_REG_OTP
      || awAddr_q == `HBCS_REG_HOST;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awAddr_q <= '0;
         wData_q <= '0;
         wStrb_q <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `HBCS_RESP_OKAY;
         ctrl_q <= `HBCS_CTRL_RST;
         otpCfg_q <= '0;
         otpMask_q <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrHit ? `HBCS_RESP_OKAY : `HBCS_RESP_SLVERR;
            if (awAddr_q == `HBCS_REG_CTRL && wStrb_q[0]) begin
               ctrl_q[7:0] <= wData_q[7:0];
            end
            if (awAddr_q == `HBCS_REG_OTP) begin
               otpCfg_q <= wData_q;
               otpMask_q <= otpMask_q | {{8{wStrb_q[3]}}, {8{wStrb_q[2]}},
                  {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI4-Lite read
   logic [31:0] rdMux;
   logic rdHit;
   assign s_axi_arready = !s_axi_rvalid;
   assign rdHit = s_axi_araddr == `HBCS_REG_CTRL || s_axi_araddr == `HBCS_REG_STATUS
      || s_axi_araddr == `HBCS_REG_CFG || s_axi_araddr == `HBCS_REG_STRAPS
      || s_axi_araddr == `HBCS_REG_HOST || s_axi_araddr == `HBCS_REG_OTP
      || s_axi_araddr == `HBCS_REG_ROM;
   assign rdMux = (s_axi_araddr == `HBCS_REG_CTRL) ? ctrl_q
      : (s_axi_araddr == `HBCS_REG_STATUS) ? {24'h000000, highspeedAttach,
         smbusSlaveEn, flashExecute, pllRun, stage_q}
      : (s_axi_araddr == `HBCS_REG_CFG) ? cfg_q
      : (s_axi_araddr == `HBCS_REG_STRAPS) ? {14'h0000, straps_q}
      : (s_axi_araddr == `HBCS_REG_HOST) ? hostCfg_q
      : (s_axi_araddr == `HBCS_REG_OTP) ? otpCfg_q
      : (s_axi_araddr == `HBCS_REG_ROM) ? `HBCS_ROM_DEFAULT : 32'h00000000;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `HBCS_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdMux;
         s_axi_rresp <= rdHit ? `HBCS_RESP_OKAY : `HBCS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Checks
   property p_standby;
      @(posedge clk) !reset_n |=> stage_q == StStandby && !portsEnable;
   endproperty
   a_standby: assert property (p_standby) else $error("not standby");
   property p_release;
      @(posedge clk) disable iff (!reset_n) reset_n && stage_q == StStandby
         |=> stage_q == StFlashProbe;
   endproperty
   a_release: assert property (p_release) else $error("no probe");
   property p_noflash;
      @(posedge clk) disable iff (!reset_n) stage_q == StFlashProbe
         && !straps_q.flashMode |=> stage_q == StCfgRom;
   endproperty
   a_noflash: assert property (p_noflash) else $error("no skip");
   sequence s_sig_ok;
      stage_q == StFlashProbe && straps_q.flashMode && flashDone && sigOk;
   endsequence
   property p_sig;
      @(posedge clk) disable iff (!reset_n) s_sig_ok |=> flashExecute;
   endproperty
   a_sig: assert property (p_sig) else $error("no exec");
   property p_rom_strap;
      @(posedge clk) disable iff (!reset_n) stage_q == StCfgRom
         |=> stage_q == StStrap ##1 stage_q inside {StPullProbe, StOtpMerge};
   endproperty
   a_rom_strap: assert property (p_rom_strap) else $error("bad order");
   property p_hostwait;
      @(posedge clk) disable iff (!reset_n) stage_q == StHostCfg && !hostEnd
         |=> stage_q == StHostCfg;
   endproperty
   a_hostwait: assert property (p_hostwait) else $error("left early");
   property p_attach_end;
      @(posedge clk) disable iff (!reset_n) stage_q == StHostCfg && hostEnd
         |=> stage_q == StOtpMerge ##1 highspeedAttach && superspeedHubEnable;
   endproperty
   a_attach_end: assert property (p_attach_end) else $error("no attach");
   property p_otp_wins;
      @(posedge clk) disable iff (!reset_n) stage_q == StOtpMerge
         |=> ((cfg_q ^ $past(otpCfg_q)) & $past(otpMask_q)) == 32'h00000000;
   endproperty
   a_otp_wins: assert property (p_otp_wins) else $error("otp lost");
   property p_softdisc;
      @(posedge clk) disable iff (!reset_n) stage_q == StNormal && softDisconnect
         |=> stage_q == StAttach && !portsEnable;
   endproperty
   a_softdisc: assert property (p_softdisc) else $error("no return");
   property p_req_pulse;
      @(posedge clk) disable iff (!reset_n) flashReq.req |=> !flashReq.req;
   endproperty
   a_req_pulse: assert property (p_req_pulse) else $error("req held");
   property p_noreq_idle;
      @(posedge clk) disable iff (!reset_n) stage_q != StFlashProbe |-> !flashReq.req;
   endproperty
   a_noreq_idle: assert property (p_noreq_idle) else $error("stray req");
   property p_probe_addr;
      @(posedge clk) disable iff (!reset_n) stage_q == StFlashProbe
         |-> flashReq.addr == `HBCS_SIG_ADDR;
   endproperty
   a_probe_addr: assert property (p_probe_addr) else $error("bad probe addr");
   sequence s_sig_bad;
      stage_q == StFlashProbe && straps_q.flashMode && flashDone && !sigOk;
   endsequence
   property p_badsig;
      @(posedge clk) disable iff (!reset_n) s_sig_bad |=> stage_q == StCfgRom;
   endproperty
   a_badsig: assert property (p_badsig) else $error("no rom fallback");
   property p_exec_hold;
      @(posedge clk) disable iff (!reset_n) stage_q == StFlashExec
         |=> flashExecute && flashReq.addr == `HBCS_EXEC_ADDR;
   endproperty
   a_exec_hold: assert property (p_exec_hold) else $error("exec lost");
   property p_rom_load;
      @(posedge clk) disable iff (!reset_n) stage_q == StCfgRom
         |=> cfg_q == `HBCS_ROM_DEFAULT;
   endproperty
   a_rom_load: assert property (p_rom_load) else $error("rom not loaded");
   logic [16:0] strapImage;
   assign strapImage = straps_q[17:1];
   property p_strap_load;
      @(posedge clk) disable iff (!reset_n) stage_q == StStrap
         |=> cfg_q[16:0] == $past(strapImage);
   endproperty
   a_strap_load: assert property (p_strap_load) else $error("straps not applied");
   property p_pull_found;
      @(posedge clk) disable iff (!reset_n) stage_q == StPullProbe && pullProbeDone
         && pullUpsFound |=> stage_q == StHostCfg && smbusSlaveEn;
   endproperty
   a_pull_found: assert property (p_pull_found) else $error("no slave");
   property p_pull_missing;
      @(posedge clk) disable iff (!reset_n) stage_q == StPullProbe && pullProbeDone
         && !pullUpsFound |=> stage_q == StOtpMerge;
   endproperty
   a_pull_missing: assert property (p_pull_missing) else $error("no otp skip");
   property p_host_leave;
      @(posedge clk) disable iff (!reset_n) stage_q == StHostCfg && stageDone |-> hostEnd;
   endproperty
   a_host_leave: assert property (p_host_leave) else $error("host left");
   property p_attach_wait;
      @(posedge clk) disable iff (!reset_n) stage_q == StAttach
         && !(hostConnected && !softDisconnect) |=> stage_q == StAttach;
   endproperty
   a_attach_wait: assert property (p_attach_wait) else $error("attach left");
   property p_attach_go;
      @(posedge clk) disable iff (!reset_n) stage_q == StAttach && hostConnected
         && !softDisconnect |=> portsEnable;
   endproperty
   a_attach_go: assert property (p_attach_go) else $error("no normal");
endmodule : hbcs_sequencer

// *** verif/hbcs_far_model.sv ***
// Purpose: Flash, pull-up probe and SMBus master beside the sequencer
// Assumes: Answers on clk, flash slower for a bad signature
// Notes: endKind 0 none, 1 legacy end, 2 attach, 3 attach-keep opcode, SMBus slave still drops after it
`include "hbcs_params.svh"
module hbcs_far_model (
   input wire logic clk,
   input wire hbcs_pkg::hbcs_flash_req_t flashReq,
   input wire logic pullProbeStart,
   input wire logic smbusSlaveEn,
   input wire logic sigGood,
   input wire logic pullOk,
   input wire logic [1:0] endKind,
   output logic flashDone,
   output logic [31:0] flashData,
   output logic pullUpsFound,
   output logic pullProbeDone,
   output hbcs_pkg::hbcs_host_cmd_t hostCmd
);
   timeunit 1ns;
   timeprecision 1ps;
   import hbcs_pkg::*;
   logic [3:0] fCnt = 4'h0;
   logic [3:0] pCnt = 4'h0;
   logic [7:0] hCnt = 8'h0;
   logic [15:0] op;
   assign op = endKind[0] ? `HBCS_OP_ATTACH_KEEP : `HBCS_OP_ATTACH;
   assign pullUpsFound = pullOk;
   initial begin
      flashDone = 1'b0;
      flashData = 32'h0;
      pullProbeDone = 1'b0;
      hostCmd = '0;
   end
   always @(posedge clk) begin
      flashDone <= 1'b0;
      pullProbeDone <= 1'b0;
      hostCmd <= '0;
      // Idle data line toggles, never keeps the last word
      flashData <= ~flashData;
      // Part taken as 2 Mbit, 60 MHz capable
      fCnt <= flashReq.req ? (sigGood ? 4'h2 : 4'h9) : fCnt - {3'h0, fCnt != 4'h0};
      if (fCnt == 4'h1) begin
         flashDone <= 1'b1;
         flashData <= sigGood ? `HBCS_SIG_WORD : 32'h32444654;
      end
      pCnt <= pullProbeStart ? pCnt + {3'h0, pCnt != 4'hf} : 4'h0;
      pullProbeDone <= pCnt == 4'h4;
      hCnt <= smbusSlaveEn ? hCnt + {7'h0, hCnt != 8'hff} : 8'h0;
      // Unknown opcode first, must not end configuration
      if (hCnt == 8'h14) hostCmd <= {1'b1, 1'b0, 8'h00, 16'haa57};
      if (hCnt == 8'hc8 && endKind == 2'h1) hostCmd <= {2'b11, `HBCS_LEGACY_END_REG, 16'h0};
      if (hCnt == 8'hc8 && endKind[1]) hostCmd <= {2'b10, 8'h00, op};
   end
endmodule : hbcs_far_model

// *** verif/test_hub_boot_config_sequencer.sv ***
// Purpose: Self-checking bench for the boot stage sequencer
// Assumes: Stage read back from STATUS[3:0] over AXI4-Lite
// Notes: Straps set while reset is low
`include "hbcs_params.svh"
module test_hub_boot_config_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   import hbcs_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   hbcs_straps_t strapPins = '0;
   hbcs_straps_t cur;
   hbcs_flash_req_t flashReq;
   hbcs_host_cmd_t hostCmd;
   logic pullUpsFound, pullProbeDone, flashDone, pullProbeStart, smbusSlaveEn;
   logic highspeedAttach, superspeedHubEnable, portsEnable, pllRun, flashExecute;
   logic hostConnected = 1'b0, softDisconnect = 1'b0, sigGood = 1'b0, pullOk = 1'b0;
   logic [31:0] flashData, mergedCfg, s_axi_rdata, rd;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [1:0] endKind = 2'h0;
   logic [3:0] ctv [4] = '{4'h0, 4'h2, 4'h4, 4'hc};
   logic [1:0] ctl [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
   int failCount = 0, cmpCount = 0;
   always #5 clk = ~clk;
   hbcs_sequencer i_dut (.clk, .reset_n, .strapPins, .pullUpsFound, .pullProbeDone, .flashReq,
      .flashDone, .flashData, .hostCmd, .hostConnected, .softDisconnect, .pullProbeStart,
      .smbusSlaveEn, .highspeedAttach, .superspeedHubEnable, .portsEnable, .pllRun, .flashExecute,
      .mergedCfg, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   hbcs_far_model i_far (.clk, .flashReq, .pullProbeStart, .smbusSlaveEn, .sigGood, .pullOk,
      .endKind, .flashDone, .flashData, .pullUpsFound, .pullProbeDone, .hostCmd);
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmpCount++;
      if (g !== e) begin
         failCount++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task closeOut;
      $display("Comparisons %0d, mismatches %0d", cmpCount, failCount);
      if (failCount == 0 && cmpCount > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : closeOut
   task axWr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
             input logic [1:0] er);
      logic pa, pw;
      pa = 1'b1;
      pw = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (pa || pw) begin
         @(negedge clk);
         pa = pa && !s_axi_awready;
         pw = pw && !s_axi_wready;
         @(posedge clk);
         s_axi_awvalid <= pa;
         s_axi_wvalid <= pw;
         s_axi_bready <= !(pa || pw);
      end
      do @(negedge clk); while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      @(posedge clk);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, rsp});
   endtask : axWr
   task axRd(input logic [11:0] a, input logic [1:0] er);
      logic pa;
      pa = 1'b1;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      while (pa) begin
         @(negedge clk);
         pa = !s_axi_arready;
         @(posedge clk);
         s_axi_arvalid <= pa;
         s_axi_rready <= !pa;
      end
      do @(negedge clk); while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clk);
      s_axi_rready <= 1'b0;
      chk("rresp", {30'h0, er}, {30'h0, rsp});
   endtask : axRd
   task waitStage(input logic [3:0] st);
      int n;
      n = 0;
      do begin
         axRd(`HBCS_REG_STATUS, `HBCS_RESP_OKAY);
         n++;
      end while (rd[3:0] !== st && n < 150);
      chk("stage", {28'h0, st}, {28'h0, rd[3:0]});
   endtask : waitStage
   task boot(input logic [2:0] cs, input logic fm, input logic g, input logic p,
             input logic [1:0] k, input logic [3:0] st);
      cur = {cs, 6'h2d, 6'h13, 1'b1, 1'b0, fm};
      reset_n <= 1'b0;
      strapPins <= cur;
      sigGood <= g;
      pullOk <= p;
      endKind <= k;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      waitStage(st);
   endtask : boot
   task quiet;
      chk("standby", 32'h0, {26'h0, portsEnable, pllRun, highspeedAttach, superspeedHubEnable,
          smbusSlaveEn, flashExecute});
   endtask : quiet
   initial begin
      repeat (20000) @(posedge clk);
      failCount++;
      closeOut;
   end
   initial begin
      repeat (2) @(posedge clk);
      quiet;
      reset_n <= 1'b1;
      axRd(`HBCS_REG_CTRL, `HBCS_RESP_OKAY);
      chk("ctrlReset", `HBCS_CTRL_RST, rd);
      for (int i = 0; i < 4; i++) begin
         axWr(`HBCS_REG_CTRL, {28'h0, ctv[i]}, 4'h1, `HBCS_RESP_OKAY);
         chk("lanes", {29'h0, ctl[i], ctv[i][3]}, {29'h0, flashReq.lanes, flashReq.cpol});
      end
      axRd(`HBCS_REG_CTRL, `HBCS_RESP_OKAY);
      chk("ctrlBack", 32'hc, rd);
      axRd(12'h100, `HBCS_RESP_SLVERR);
      chk("unmapped", 32'h0, rd);
      axWr(12'h104, 32'h1, 4'hf, `HBCS_RESP_SLVERR);
      boot(3'h0, 1'b1, 1'b1, 1'b0, 2'h0, 4'h2);
      chk("execAddr", {8'h0, `HBCS_EXEC_ADDR}, {8'h0, flashReq.addr});
      chk("exec", 32'h1, {31'h0, flashExecute});
      boot(3'h2, 1'b1, 1'b0, 1'b0, 2'h0, 4'h8);
      axRd(`HBCS_REG_CFG, `HBCS_RESP_OKAY);
      chk("cfg", {15'h0, cur[17:1]}, rd);
      chk("attach", 32'h3, {30'h0, highspeedAttach, superspeedHubEnable});
      hostConnected <= 1'b1;
      waitStage(4'h9);
      softDisconnect <= 1'b1;
      waitStage(4'h8);
      softDisconnect <= 1'b0;
      waitStage(4'h9);
      reset_n <= 1'b0;
      hostConnected <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      quiet;
      @(posedge clk);
      boot(3'h1, 1'b0, 1'b0, 1'b0, 2'h0, 4'h8);
      boot(3'h1, 1'b0, 1'b0, 1'b1, 2'h0, 4'h6);
      chk("slave", 32'h1, {31'h0, smbusSlaveEn});
      repeat (300) @(posedge clk);
      waitStage(4'h6);
      for (int k = 1; k < 4; k++) begin
         boot(3'h1, 1'b0, 1'b0, 1'b1, 2'(k), 4'h6);
         axWr(`HBCS_REG_HOST, 32'h12345678, 4'h3, `HBCS_RESP_OKAY);
         axWr(`HBCS_REG_OTP, 32'h0000abcd, 4'h1, `HBCS_RESP_OKAY);
         waitStage(4'h8);
         axRd(`HBCS_REG_CFG, `HBCS_RESP_OKAY);
         chk("merge", ({15'h0, cur[17:1]} & 32'hffff0000) | 32'h56cd, rd);
         chk("mergedCfg", ({15'h0, cur[17:1]} & 32'hffff0000) | 32'h56cd, mergedCfg);
      end
      boot(3'h4, 1'b0, 1'b0, 1'b0, 2'h0, 4'h8);
      axRd(`HBCS_REG_OTP, `HBCS_RESP_OKAY);
      chk("otpCleared", 32'h0, rd);
      axRd(`HBCS_REG_CFG, `HBCS_RESP_OKAY);
      chk("cfgFresh", {15'h0, cur[17:1]}, rd);
      closeOut;
   end
endmodule : test_hub_boot_config_sequencer
